// *** rtl/pbi_pkg.sv ***
// Package with shared constants and types of the bus interface block.
package pbi_pkg;
    // ************************************************************
    // Bus commands and sizes
    // ************************************************************
    localparam logic [3:0] CMD_MEM_RD   = 4'h6;
    localparam logic [3:0] CMD_MEM_WR   = 4'h7;
    localparam logic [3:0] CMD_CFG_RD   = 4'hA;
    localparam logic [3:0] CMD_CFG_WR   = 4'hB;
    localparam int         DATA_W       = 32;
    localparam int         FIFO_DEPTH   = 8;
    localparam logic [2:0] ABORT_CYCLES = 3'h5;
    localparam logic [31:0] ADDR_STEP   = 32'h0000_0004;
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;

    // One accepted target write, handed to the user side.
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  be_n;
    } pbi_wr_type;

    typedef enum logic [1:0] {T_IDLE, T_SEL, T_DATA, T_TAR} pbi_tgt_type;
    typedef enum logic [2:0] {I_IDLE, I_REQ, I_ADDR, I_DATA, I_TAR} pbi_ini_type;
endpackage

// *** rtl/pbi_top.sv ***
// Bus interface: target, single-word initiator, write FIFO and interrupt pin.

// ************************************************************
// Write buffer
// ************************************************************
module pbi_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic [WIDTH-1:0]      out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid_in && in_ready_out;
    wire              pop  = out_valid_out && out_ready_in;

    assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem[rp_q];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage carries no reset so it maps onto plain memory.
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wp_q] <= in_data_in;
        end
    end
endmodule

module pbi_top #(
    parameter logic [31:0] MEM_BASE = 32'h0800_0000,
    parameter logic [31:0] MEM_MASK = 32'hFE00_0000,
    parameter logic [31:0] CFG_ID   = 32'h0001_1234  // Arbitrary identity word.
) (
    input  wire logic        CLK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic [31:0] AD_IN,
    output logic      [31:0] AD_OUT,
    output logic             AD_OE_N_OUT,
    input  wire logic [3:0]  CBE_N_IN,
    output logic      [3:0]  CBE_N_OUT,
    output logic             CBE_OE_N_OUT,
    input  wire logic        FRAME_N_IN,
    output logic             FRAME_N_OUT,
    output logic             FRAME_OE_N_OUT,
    input  wire logic        IRDY_N_IN,
    output logic             IRDY_N_OUT,
    output logic             IRDY_OE_N_OUT,
    input  wire logic        TRDY_N_IN,
    output logic             TRDY_N_OUT,
    output logic             TRDY_OE_N_OUT,
    input  wire logic        DEVSEL_N_IN,
    output logic             DEVSEL_N_OUT,
    output logic             DEVSEL_OE_N_OUT,
    input  wire logic        STOP_N_IN,
    output logic             PAR_OUT,
    output logic             PAR_OE_N_OUT,
    input  wire logic        IDSEL_IN,
    input  wire logic        GNT_N_IN,
    output logic             REQ_N_OUT,
    output logic             REQ_OE_N_OUT,
    output logic             INTA_N_OUT,
    output logic             INTA_OE_N_OUT,
    input  wire logic        IRQ_IN,
    output pbi_pkg::pbi_wr_type WR_WORD_OUT,
    output logic             WR_VALID_OUT,
    input  wire logic        WR_READY_IN,
    output logic      [31:0] RD_ADDR_OUT,
    input  wire logic [31:0] RD_DATA_IN,
    input  wire logic        INIT_REQ_IN,
    input  wire logic [31:0] INIT_ADDR_IN,
    input  wire logic [31:0] INIT_DATA_IN,
    input  wire logic [3:0]  INIT_BE_IN,
    output logic             INIT_DONE_OUT,
    output logic             INIT_ABORT_OUT
);
    pbi_pkg::pbi_tgt_type t_q;
    pbi_pkg::pbi_ini_type i_q;
    logic [31:0] t_addr_q;
    logic        t_wr_q;
    logic        t_cfg_q;
    logic [31:0] rd_q;
    logic        rd_ok_q;
    logic        idle_q;
    logic [31:0] i_addr_q;
    logic [31:0] i_data_q;
    logic [3:0]  i_be_q;
    logic        i_retry_q;
    logic [2:0]  i_cnt_q;
    logic        par_q;
    logic        par_oe_n_q;
    logic        req_oe_n_q;
    logic        irq_q;
    logic        done_q;
    logic        abort_q;
    logic        fifo_ready;

    // ************************************************************
    // Target decode
    // ************************************************************
    wire [3:0] cmd      = CBE_N_IN;
    wire addr_phase     = !FRAME_N_IN && idle_q && (i_q == pbi_pkg::I_IDLE
                          || i_q == pbi_pkg::I_REQ);
    wire mem_hit        = ((AD_IN & MEM_MASK) == MEM_BASE)
                          && (cmd == pbi_pkg::CMD_MEM_RD || cmd == pbi_pkg::CMD_MEM_WR);
    wire cfg_hit        = IDSEL_IN && (cmd == pbi_pkg::CMD_CFG_RD
                          || cmd == pbi_pkg::CMD_CFG_WR);
    wire t_claim        = addr_phase && (mem_hit || cfg_hit) && (t_q == pbi_pkg::T_IDLE);
    wire t_live         = (t_q == pbi_pkg::T_SEL) || (t_q == pbi_pkg::T_DATA);
    wire t_trdy         = (t_q == pbi_pkg::T_DATA) && (t_wr_q ? (fifo_ready || t_cfg_q)
                          : rd_ok_q);
    wire t_done         = t_trdy && !IRDY_N_IN;
    wire t_rd_drive     = (t_q == pbi_pkg::T_DATA) && !t_wr_q;
    wire [31:0] rd_src  = t_cfg_q ? ((t_addr_q[7:2] == 6'h00) ? CFG_ID : pbi_pkg::RST_WORD)
                          : RD_DATA_IN;
    wire push           = t_done && t_wr_q && !t_cfg_q;
    wire i_drive        = (i_q == pbi_pkg::I_ADDR) || (i_q == pbi_pkg::I_DATA);
    wire bus_free       = FRAME_N_IN && IRDY_N_IN;
    wire i_trdy_seen    = (i_q == pbi_pkg::I_DATA) && !TRDY_N_IN;
    wire i_stop_seen    = (i_q == pbi_pkg::I_DATA) && TRDY_N_IN && !STOP_N_IN;
    wire i_abort        = (i_q == pbi_pkg::I_DATA) && DEVSEL_N_IN
                          && (i_cnt_q == pbi_pkg::ABORT_CYCLES);

    pbi_pkg::pbi_wr_type wr_in;
    assign wr_in = '{addr: t_addr_q, data: AD_IN, be_n: CBE_N_IN};

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            t_q      <= pbi_pkg::T_IDLE;
            t_addr_q <= pbi_pkg::RST_WORD;
            t_wr_q   <= 1'b0;
            t_cfg_q  <= 1'b0;
            rd_ok_q  <= 1'b0;
            idle_q   <= 1'b0;
        end else begin
            idle_q <= bus_free;
            case (t_q)
                pbi_pkg::T_IDLE: begin
                    if (t_claim) begin
                        t_q      <= pbi_pkg::T_SEL;
                        t_addr_q <= AD_IN;
                        t_wr_q   <= cmd[0];
                        t_cfg_q  <= cfg_hit;
                    end
                end
                pbi_pkg::T_SEL: begin
                    t_q <= pbi_pkg::T_DATA;
                end
                pbi_pkg::T_DATA: begin
                    if (t_done) begin
                        t_addr_q <= t_addr_q + pbi_pkg::ADDR_STEP;
                    end
                    if ((t_done && FRAME_N_IN) || bus_free) begin
                        t_q <= pbi_pkg::T_TAR;
                    end
                end
                pbi_pkg::T_TAR: begin
                    t_q <= pbi_pkg::T_IDLE;
                end
                default: begin
                    t_q <= pbi_pkg::T_IDLE;
                end
            endcase
            // Reads insert one wait state per word so the fetched word always
            // matches the address shown to the user.
            rd_ok_q <= t_rd_drive && !t_done;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!rd_ok_q) begin
            rd_q <= rd_src;
        end
    end

    // ************************************************************
    // Initiator: single-word memory write
    // ************************************************************
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            i_q        <= pbi_pkg::I_IDLE;
            i_addr_q   <= pbi_pkg::RST_WORD;
            i_data_q   <= pbi_pkg::RST_WORD;
            i_be_q     <= 4'h0;
            i_retry_q  <= 1'b0;
            i_cnt_q    <= 3'h0;
            done_q     <= 1'b0;
            abort_q    <= 1'b0;
            req_oe_n_q <= 1'b1;
        end else begin
            req_oe_n_q <= 1'b0;
            done_q     <= i_trdy_seen;
            abort_q    <= i_abort;
            case (i_q)
                pbi_pkg::I_IDLE: begin
                    if (INIT_REQ_IN) begin
                        i_q      <= pbi_pkg::I_REQ;
                        i_addr_q <= INIT_ADDR_IN;
                        i_data_q <= INIT_DATA_IN;
                        i_be_q   <= INIT_BE_IN;
                    end
                end
                pbi_pkg::I_REQ: begin
                    if (!GNT_N_IN && bus_free && t_q == pbi_pkg::T_IDLE
                        && !t_claim) begin
                        i_q <= pbi_pkg::I_ADDR;
                    end
                end
                pbi_pkg::I_ADDR: begin
                    i_q     <= pbi_pkg::I_DATA;
                    i_cnt_q <= 3'h0;
                end
                pbi_pkg::I_DATA: begin
                    i_cnt_q <= i_cnt_q + 3'h1;
                    if (i_trdy_seen || i_stop_seen || i_abort) begin
                        i_q       <= pbi_pkg::I_TAR;
                        i_retry_q <= i_stop_seen;
                    end
                end
                pbi_pkg::I_TAR: begin
                    i_q       <= i_retry_q ? pbi_pkg::I_REQ : pbi_pkg::I_IDLE;
                    i_retry_q <= 1'b0;
                end
                default: begin
                    i_q <= pbi_pkg::I_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Pin drive and parity
    // ************************************************************
    assign AD_OUT          = (i_q == pbi_pkg::I_ADDR) ? i_addr_q
                           : (i_q == pbi_pkg::I_DATA) ? i_data_q : rd_q;
    assign AD_OE_N_OUT     = !(i_drive || t_rd_drive);
    assign CBE_N_OUT       = (i_q == pbi_pkg::I_ADDR) ? pbi_pkg::CMD_MEM_WR
                           : ~i_be_q;
    assign CBE_OE_N_OUT    = !i_drive;
    assign FRAME_N_OUT     = (i_q != pbi_pkg::I_ADDR);
    assign FRAME_OE_N_OUT  = !i_drive;
    assign IRDY_N_OUT      = (i_q != pbi_pkg::I_DATA);
    assign IRDY_OE_N_OUT   = !(i_drive || i_q == pbi_pkg::I_TAR);
    assign DEVSEL_N_OUT    = !t_live;
    assign DEVSEL_OE_N_OUT = !(t_live || t_q == pbi_pkg::T_TAR);
    assign TRDY_N_OUT      = !t_trdy;
    assign TRDY_OE_N_OUT   = DEVSEL_OE_N_OUT;
    assign PAR_OUT         = par_q;
    assign PAR_OE_N_OUT    = par_oe_n_q;
    assign REQ_N_OUT       = (i_q != pbi_pkg::I_REQ);
    assign REQ_OE_N_OUT    = req_oe_n_q;
    assign INTA_N_OUT      = 1'b0;
    assign INTA_OE_N_OUT   = !irq_q;
    assign RD_ADDR_OUT     = t_addr_q;
    assign INIT_DONE_OUT   = done_q;
    assign INIT_ABORT_OUT  = abort_q;

    wire [3:0] cbe_bus = CBE_OE_N_OUT ? CBE_N_IN : CBE_N_OUT;

    // Parity lags its word by one clock, so it is driven one clock longer.
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            par_q      <= 1'b0;
            par_oe_n_q <= 1'b1;
            irq_q      <= 1'b0;
        end else begin
            par_q      <= ^{AD_OUT, cbe_bus};
            par_oe_n_q <= AD_OE_N_OUT;
            irq_q      <= IRQ_IN;
        end
    end

    pbi_fifo #(.WIDTH($bits(pbi_pkg::pbi_wr_type)), .DEPTH(pbi_pkg::FIFO_DEPTH)) u_fifo (
        .clk_in        (CLK_IN),
        .rst_in        (SYS_RST_IN),
        .in_data_in    (wr_in),
        .in_valid_in   (push),
        .in_ready_out  (fifo_ready),
        .out_data_out  (WR_WORD_OUT),
        .out_valid_out (WR_VALID_OUT),
        .out_ready_in  (WR_READY_IN)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    sequence s_hit;
        t_claim;
    endsequence
    sequence s_stop;
        i_stop_seen ##1 (i_q == pbi_pkg::I_TAR);
    endsequence

    a_devsel_on_hit: assert property (s_hit |=> (!DEVSEL_N_OUT && !DEVSEL_OE_N_OUT) [*2])
        else $error("device select missing after address hit");
    a_cfg_needs_idsel: assert property (addr_phase && !IDSEL_IN && !mem_hit
        && t_q == pbi_pkg::T_IDLE |=> DEVSEL_OE_N_OUT)
        else $error("configuration claimed without select");
    a_start_granted: assert property (i_q == pbi_pkg::I_ADDR |-> $past(!GNT_N_IN))
        else $error("transaction started without grant");
    a_frame_last: assert property (i_q == pbi_pkg::I_ADDR |=> FRAME_N_OUT && !IRDY_N_OUT
        && !AD_OE_N_OUT && AD_OUT == i_data_q)
        else $error("frame or data wrong in final phase");
    a_push_both_rdy: assert property (push |-> !IRDY_N_IN && !TRDY_N_OUT)
        else $error("write accepted without both ready");
    a_par_even: assert property (!AD_OE_N_OUT |=> !PAR_OE_N_OUT
        && PAR_OUT == ^{$past(AD_OUT), $past(cbe_bus)})
        else $error("parity wrong or late");
    a_irq_drive: assert property (IRQ_IN |=> !INTA_OE_N_OUT ##1 (INTA_OE_N_OUT == !$past(IRQ_IN)))
        else $error("interrupt pin not following request");
    a_stop_honour: assert property (i_stop_seen |-> s_stop ##1 i_q == pbi_pkg::I_REQ)
        else $error("stop not honoured");
    a_req_on_need: assert property (INIT_REQ_IN && i_q == pbi_pkg::I_IDLE |=> !REQ_N_OUT)
        else $error("request not raised");
    a_read_trdy: assert property (!TRDY_N_OUT && !t_wr_q |-> !AD_OE_N_OUT && AD_OUT == rd_q)
        else $error("read ready without data");
endmodule

// *** dv/pbi_host_model.sv ***
// Host side of the bus: line resolution with pull-ups, arbiter and a memory target.
module pbi_host_model (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [31:0] dut_ad_in,
    input  wire logic [3:0]  dut_cbe_in,
    input  wire logic [5:0]  dut_oe_n_in,
    input  wire logic [3:0]  dut_ctl_n_in,
    input  wire logic [1:0]  dut_req_in,
    input  wire logic [31:0] h_ad_in,
    input  wire logic        h_ad_oe_in,
    input  wire logic [3:0]  h_cbe_in,
    input  wire logic        h_oe_in,
    input  wire logic        h_frame_n_in,
    input  wire logic        h_irdy_n_in,
    input  wire logic [1:0]  mode_in,
    input  wire logic [2:0]  slow_in,
    output logic      [31:0] ad_out,
    output logic      [3:0]  cbe_out,
    output logic      [4:0]  ctl_n_out,
    output logic             gnt_n_out
);
    logic [31:0] ad_last_q, got_addr_q, got_data_q;
    logic [3:0]  cbe_last_q, got_cmd_q, got_be_q;
    logic [2:0]  cnt_q;
    logic        act_q, stopped_q, go, frame_n, irdy_n, trdy_n, devsel_n, stop_n;
    // Released lines without pull-up show the inverse of their last value, so that a
    // stale value never passes for a driven one. Mode 0 answers, 1 stops once, 2 is silent.
    assign ad_out = !dut_oe_n_in[5] ? dut_ad_in : h_ad_oe_in ? h_ad_in : ~ad_last_q;
    assign cbe_out = !dut_oe_n_in[4] ? dut_cbe_in : h_oe_in ? h_cbe_in : ~cbe_last_q;
    assign frame_n = !dut_oe_n_in[3] ? dut_ctl_n_in[3] : !h_oe_in | h_frame_n_in;
    assign irdy_n = !dut_oe_n_in[2] ? dut_ctl_n_in[2] : !h_oe_in | h_irdy_n_in;
    assign go = act_q && cnt_q >= slow_in;
    assign trdy_n = !dut_oe_n_in[1] ? dut_ctl_n_in[1]
                  : !(go && (mode_in == 2'h0 || (mode_in == 2'h1 && stopped_q)));
    assign devsel_n = !dut_oe_n_in[0] ? dut_ctl_n_in[0] : !(act_q && mode_in != 2'h2);
    assign stop_n = !(go && mode_in == 2'h1 && !stopped_q);
    assign ctl_n_out = {frame_n, irdy_n, trdy_n, devsel_n, stop_n};

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            {ad_last_q, got_addr_q, got_data_q} <= '0;
            {cbe_last_q, got_cmd_q, got_be_q, cnt_q} <= '0;
            {act_q, stopped_q} <= 2'b00;
            gnt_n_out <= 1'b1;
        end else begin
            ad_last_q <= ad_out;
            cbe_last_q <= cbe_out;
            gnt_n_out <= dut_req_in != 2'b00;
            cnt_q <= act_q ? cnt_q + 3'h1 : 3'h0;
            if (!act_q && !dut_oe_n_in[3] && !frame_n) begin
                act_q <= 1'b1;
                got_addr_q <= ad_out;
                got_cmd_q <= cbe_out;
            end else if (act_q && !irdy_n && !trdy_n) begin
                act_q <= 1'b0;
                got_data_q <= ad_out;
                got_be_q <= cbe_out;
            end else if (act_q && !irdy_n && !stop_n) begin
                act_q <= 1'b0;
                stopped_q <= 1'b1;
            end else if (act_q && dut_oe_n_in[3] && dut_oe_n_in[2]) begin
                act_q <= 1'b0;
            end
        end
    end
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the bus interface block.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] CFG_WORD = 32'h0000_5A5A; // Arbitrary identity word.
    localparam logic [31:0] BASE = 32'h0800_0000;
    logic        clk, rst, irq, wr_rdy, ireq, h_ad_oe, h_oe, h_frame_n, h_irdy_n, idsel;
    logic [31:0] iaddr, idata, h_ad;
    logic [3:0]  ibe, h_cbe;
    logic [1:0]  mode;
    logic [2:0]  slow;
    logic        par_due = 1'b0;
    logic        par_exp = 1'b0;
    logic [67:0] exp_q[$];
    int          n_fail = 0;
    int          checks = 0;
    wire logic [31:0] ad, ad_o, rd_addr;
    wire logic [3:0]  cbe, cbe_o, ctl_o;
    wire logic [5:0]  oe_n;
    wire logic [4:0]  ctl;
    wire logic [1:0]  req;
    wire logic        gnt_n, par, par_oe_n, inta, inta_oe_n, wr_valid, done, abort;
    wire pbi_pkg::pbi_wr_type wr_word;

    pbi_top #(.CFG_ID(CFG_WORD)) u_dut (
        .CLK_IN(clk), .SYS_RST_IN(rst), .AD_IN(ad), .AD_OUT(ad_o), .AD_OE_N_OUT(oe_n[5]),
        .CBE_N_IN(cbe), .CBE_N_OUT(cbe_o), .CBE_OE_N_OUT(oe_n[4]), .FRAME_N_IN(ctl[4]),
        .FRAME_N_OUT(ctl_o[3]), .FRAME_OE_N_OUT(oe_n[3]), .IRDY_N_IN(ctl[3]),
        .IRDY_N_OUT(ctl_o[2]), .IRDY_OE_N_OUT(oe_n[2]), .TRDY_N_IN(ctl[2]),
        .TRDY_N_OUT(ctl_o[1]), .TRDY_OE_N_OUT(oe_n[1]), .DEVSEL_N_IN(ctl[1]),
        .DEVSEL_N_OUT(ctl_o[0]), .DEVSEL_OE_N_OUT(oe_n[0]), .STOP_N_IN(ctl[0]),
        .PAR_OUT(par), .PAR_OE_N_OUT(par_oe_n), .IDSEL_IN(idsel), .GNT_N_IN(gnt_n),
        .REQ_N_OUT(req[1]), .REQ_OE_N_OUT(req[0]), .INTA_N_OUT(inta),
        .INTA_OE_N_OUT(inta_oe_n), .IRQ_IN(irq), .WR_WORD_OUT(wr_word),
        .WR_VALID_OUT(wr_valid), .WR_READY_IN(wr_rdy), .RD_ADDR_OUT(rd_addr),
        .RD_DATA_IN(rd_addr ^ 32'hA5A5_0000), .INIT_REQ_IN(ireq), .INIT_ADDR_IN(iaddr),
        .INIT_DATA_IN(idata), .INIT_BE_IN(ibe), .INIT_DONE_OUT(done), .INIT_ABORT_OUT(abort));

    pbi_host_model u_host (
        .clk_in(clk), .rst_in(rst), .dut_ad_in(ad_o), .dut_cbe_in(cbe_o), .dut_oe_n_in(oe_n),
        .dut_ctl_n_in(ctl_o), .dut_req_in(req), .h_ad_in(h_ad), .h_ad_oe_in(h_ad_oe),
        .h_cbe_in(h_cbe), .h_oe_in(h_oe), .h_frame_n_in(h_frame_n), .h_irdy_n_in(h_irdy_n),
        .mode_in(mode), .slow_in(slow), .ad_out(ad), .cbe_out(cbe), .ctl_n_out(ctl),
        .gnt_n_out(gnt_n));

    // ************************************************************
    // Shared tasks and monitors
    // ************************************************************
    task automatic chk(input logic [67:0] got, input logic [67:0] want);
        checks++;
        if (got !== want) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic print_verdict;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic timeout;
        chk(68'h0, 68'h1);
        print_verdict();
    endtask

    // Parity covers the previous cycle, so the expectation is kept one edge behind.
    always @(posedge clk) begin
        if (par_due) chk({par_oe_n, par}, {1'b0, par_exp});
        par_due <= !oe_n[5] && !rst;
        par_exp <= ^{ad, cbe};
        if (wr_valid && wr_rdy) chk(wr_word, exp_q.size() > 0 ? exp_q.pop_front() : 68'h0);
    end

    // Host initiator burst; cmd bit 0 set means write. A missing claim ends as master abort.
    task automatic txn(input logic [3:0] c, input logic [31:0] a, input int n,
                       input logic sel, input logic cl);
        int          w;
        logic [31:0] want;
        logic [31:0] wa;
        @(posedge clk);
        {h_oe, h_ad_oe, h_frame_n, h_ad, h_cbe, idsel} <= {2'b11, 1'b0, a, c, sel};
        @(posedge clk);
        for (int k = 0; k < n; k++) begin
            wa = a + 32'(4 * k);
            h_frame_n <= (k == n - 1);
            h_irdy_n <= 1'b0;
            {h_ad_oe, h_ad, h_cbe, idsel} <= {c[0], ~wa, 4'(k), 1'b0};
            w = 0;
            do begin
                @(posedge clk);
                w++;
                if (k == 0 && w == 1) chk(ctl[1], !cl);
            end while (ctl[2] !== 1'b0 && w < 30);
            if (w == 30) begin
                if (cl) timeout();
                break;
            end
            want = c[3] ? ((wa & 32'h0000_00FC) == 0 ? CFG_WORD : 32'h0) : wa ^ 32'hA5A5_0000;
            if (!c[0]) chk(ad, want);
            else if (!c[3]) exp_q.push_back({wa, ~wa, 4'(k)});
        end
        {h_irdy_n, h_frame_n, h_oe, h_ad_oe} <= 4'b1100;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic s_target;
        txn(pbi_pkg::CMD_MEM_WR, BASE + 32'h20, 4, 1'b0, 1'b1);
        txn(pbi_pkg::CMD_MEM_RD, BASE + 32'h40, 3, 1'b0, 1'b1);
        txn(pbi_pkg::CMD_MEM_WR, 32'h09FF_FFFC, 1, 1'b0, 1'b1);
        txn(pbi_pkg::CMD_MEM_RD, 32'h0A00_0000, 1, 1'b0, 1'b0);
        txn(pbi_pkg::CMD_CFG_WR, 32'h0000_0000, 1, 1'b0, 1'b0);
        txn(pbi_pkg::CMD_CFG_WR, 32'h0000_0000, 1, 1'b1, 1'b1);
        txn(pbi_pkg::CMD_CFG_RD, 32'h0000_0000, 2, 1'b1, 1'b1);
        txn(pbi_pkg::CMD_CFG_RD, 32'h0000_0000, 1, 1'b0, 1'b0);
    endtask

    task automatic s_fifo;
        wr_rdy <= 1'b0;
        fork
            txn(pbi_pkg::CMD_MEM_WR, BASE + 32'h100, 9, 1'b0, 1'b1);
            begin
                repeat (24) @(posedge clk);
                chk({68'(exp_q.size()), ctl[2]}, {68'h8, 1'b1});
                wr_rdy <= 1'b1;
            end
        join
        repeat (12) @(posedge clk);
        chk({68'(exp_q.size()), wr_valid}, 69'h0);
    endtask

    task automatic s_init(input logic [1:0] m, input logic [2:0] s, input logic ab);
        int w;
        {mode, slow, ireq} <= {m, s, 1'b1};
        {iaddr, idata, ibe} <= {32'h1234_5670 + 32'(s), 32'hC0DE_0000 | 32'(m), 4'h5 ^ 4'(s)};
        w = 0;
        // The request is latched when it is taken, and the done pulse shows in the turnaround
        // cycle just before the initiator is idle again, so the request is dropped once the bus request appears.
        do begin
            @(posedge clk);
            w++;
            if (req[1] === 1'b0) ireq <= 1'b0;
        end while (!(done || abort) && w < 60);
        if (w == 60) timeout();
        ireq <= 1'b0;
        chk({done, abort}, {!ab, ab});
        if (!ab) chk({u_host.got_addr_q, u_host.got_cmd_q}, {iaddr, pbi_pkg::CMD_MEM_WR});
        if (!ab) chk({u_host.got_data_q, u_host.got_be_q}, {idata, ~ibe});
        repeat (4) @(posedge clk);
    endtask

    task automatic s_irq;
        irq <= 1'b1;
        repeat (2) @(posedge clk);
        chk({inta_oe_n, inta}, 2'b00);
        irq <= 1'b0;
        repeat (2) @(posedge clk);
        chk(inta_oe_n, 1'b1);
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        {rst, irq, wr_rdy, ireq, idsel, h_ad_oe, h_oe, h_frame_n, h_irdy_n} = 9'h147;
        {iaddr, idata, ibe, h_ad, h_cbe, mode, slow} = '0;
        repeat (4) @(posedge clk);
        chk({oe_n, par_oe_n, req[0], inta_oe_n}, 9'h1FF);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(req, 2'b10);
        s_target();
        s_fifo();
        s_init(2'h0, 3'h0, 1'b0);
        s_init(2'h0, 3'h3, 1'b0);
        s_init(2'h1, 3'h1, 1'b0);
        s_init(2'h2, 3'h0, 1'b1);
        s_irq();
        print_verdict();
    end
endmodule
